// ===== uml_line_ctrl.v
// Purpose: modem-side uart line control: defaults, v.24 lines, wake-up
// Assumes: host-side pins synchronous to sys_clk_i; active low line levels
// Notes: registers over ahb-lite; zero wait states
`timescale 1ns/1ns
`include "uml_consts.vh"
module uml_line_ctrl #(
  parameter WAKE_CYC = `UML_WAKE_CYC
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire boot_done_i,
  input wire [1:0] op_mode_i,
  input wire carrier_i,
  input wire [1:0] psv_mode_i,
  input wire low_power_idle_i,
  input wire txd_n_i,
  input wire txd_driven_i,
  input wire rts_n_i,
  input wire rts_driven_i,
  input wire dtr_n_i,
  output reg rxd_o,
  output reg pin_oe_o,
  output reg cts_n_o,
  output reg dsr_n_o,
  output reg dcd_n_o,
  output reg online_cmd_req_o,
  output reg ok_result_o,
  output reg force_active_o,
  output reg idle_block_o,
  output reg uart_enable_o,
  output reg rx_ready_o
);
  ////////////////////////////////////////////////////////////////////
  // control register fields
  reg [31:0] ctrl_reg;
  reg [15:0] baud_div_reg;
  reg [7:0] tx_data_reg;
  reg tx_pend_reg;
  reg [7:0] rx_data_reg;
  reg rx_valid_reg;
  reg rx_drop_reg;
  reg init_reg;
  wire autobaud_en = ctrl_reg[0];
  wire hwfc_en = ctrl_reg[1];
  wire dsr_mode = ctrl_reg[2];
  wire dcd_mode = ctrl_reg[3];
  wire dtr_mode = ctrl_reg[4];
  wire mux_en = ctrl_reg[5];
  wire mux_fc_on = ctrl_reg[6];
  wire [2:0] fmt = ctrl_reg[10:8];
  wire [2:0] mux_ch = ctrl_reg[14:12];
  ////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [7:0] addr_reg;
  wire ahb_go = hsel_i && htrans_i[1] && hready_i;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= ahb_go && hwrite_i;
      rd_pend_reg <= ahb_go && !hwrite_i;
      if (ahb_go)
        addr_reg <= haddr_i[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // pin inputs: undriven host pins read as off via pull-up
  wire txd_lvl = txd_driven_i ? txd_n_i : 1'b1; // R10
  wire rts_lvl = rts_driven_i ? rts_n_i : 1'b1; // R15
  reg rts_prev_reg;
  reg dtr_prev_reg;
  wire rts_on = !rts_lvl;
  wire rts_rise_on = rts_prev_reg && !rts_lvl;
  wire dtr_fall_off = !dtr_prev_reg && dtr_n_i;
  wire psv_rts = (psv_mode_i == `UML_PSV_RTS) && !hwfc_en;
  ////////////////////////////////////////////////////////////////////
  // transmit engine; pause is gated before each new character
  wire tx_busy;
  wire tx_line;
  wire tx_start = tx_pend_reg && init_reg && !(hwfc_en && !rts_on); // R16 R17
  uml_tx_shift u_tx (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .baud_div_i(baud_div_reg),
    .fmt_i(fmt),
    .start_i(tx_start),
    .data_i(tx_data_reg),
    .busy_o(tx_busy),
    .txd_o(tx_line)
  );
  ////////////////////////////////////////////////////////////////////
  // receive sampler: mid-bit sampling of start, data and parity bits of the format in fmt
  reg [15:0] rdiv_reg;
  reg [3:0] rbit_reg;
  reg [8:0] rsh_reg;
  reg rbusy_reg;
  reg was_idle_reg;
  reg [3:0] rlen;
  always @* begin
    rlen = fmt[2] ? 4'h8 : ((fmt == `UML_FMT_8N1 || fmt == `UML_FMT_8N2) ? 4'h8 : 4'h9);
  end
  ////////////////////////////////////////////////////////////////////
  // wake-up timer for rts-driven power saving
  reg [31:0] wake_cnt_reg;
  wire wake_done = (wake_cnt_reg == 32'h0000_0000);
  ////////////////////////////////////////////////////////////////////
  // main control registers and software access
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `UML_CTRL_RST; // R1 R2 R3
      baud_div_reg <= `UML_BAUD_DIV_RST;
      tx_data_reg <= 8'h00;
      tx_pend_reg <= 1'b0;
      init_reg <= 1'b0;
    end else begin
      if (boot_done_i)
        init_reg <= 1'b1; // R8
      if (tx_start)
        tx_pend_reg <= 1'b0;
      if (wr_pend_reg) begin
        case (addr_reg)
          `UML_OFF_CTRL: begin
            ctrl_reg <= {17'h00000, hwdata_i[14:12] > `UML_MUX_CH_MAX ? 3'h0 : hwdata_i[14:12],
              1'b0, hwdata_i[10:8], 1'b0, hwdata_i[6:0]}; // R7 R20
          end
          `UML_OFF_TXD: begin
            tx_data_reg <= hwdata_i[7:0];
            tx_pend_reg <= 1'b1;
          end
          `UML_OFF_BAUD: begin
            if (hwdata_i[15:0] != 16'h0000)
              baud_div_reg <= hwdata_i[15:0];
          end
          default: begin
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // receiver and wake timer
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdiv_reg <= 16'h0000;
      rbit_reg <= 4'h0;
      rsh_reg <= 9'h000;
      rbusy_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_drop_reg <= 1'b0;
      was_idle_reg <= 1'b0;
      rts_prev_reg <= 1'b1;
      dtr_prev_reg <= 1'b1;
      wake_cnt_reg <= 32'h0000_0000;
    end else begin
      rts_prev_reg <= rts_lvl;
      dtr_prev_reg <= dtr_n_i;
      if (psv_rts && rts_rise_on)
        wake_cnt_reg <= WAKE_CYC; // R18
      else if (!wake_done)
        wake_cnt_reg <= wake_cnt_reg - 32'h0000_0001;
      if (rd_pend_reg && addr_reg == `UML_OFF_RXD)
        rx_valid_reg <= 1'b0;
      if (!rbusy_reg) begin
        if (init_reg && !txd_lvl) begin
          rbusy_reg <= 1'b1;
          rdiv_reg <= {1'b0, baud_div_reg[15:1]};
          rbit_reg <= 4'h0;
          was_idle_reg <= low_power_idle_i;
        end
      end else if (rdiv_reg == 16'h0000) begin
        rdiv_reg <= baud_div_reg;
        rsh_reg <= {txd_lvl, rsh_reg[8:1]};
        rbit_reg <= rbit_reg + 4'h1;
        if (rbit_reg == rlen) begin
          rbusy_reg <= 1'b0;
          if (was_idle_reg && !hwfc_en && psv_mode_i != `UML_PSV_OFF)
            rx_drop_reg <= 1'b1; // R14
          else begin
            // for 8n1 and 8n2 the last data sample is still on the line at this edge, not yet in rsh_reg
            rx_data_reg <= (rlen == 4'h9) ? rsh_reg[8:1] :
              {(fmt[2] ? 1'b0 : txd_lvl), rsh_reg[8:2]};
            rx_valid_reg <= 1'b1; // set wins over the read clear
          end
        end
      end else begin
        rdiv_reg <= rdiv_reg - 16'h0001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // v.24 output lines cts, dsr and dcd active low; control and status outputs active high
  // uart is held off in rts-driven power saving until the wake timer runs out
  wire uart_en_now = psv_rts ? (rts_on && wake_done) : 1'b1; // R19
  wire can_accept = !rx_valid_reg && uart_en_now;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_oe_o <= 1'b0; // R8
      rxd_o <= 1'b1;
      cts_n_o <= 1'b1;
      dsr_n_o <= 1'b1;
      dcd_n_o <= 1'b1;
      online_cmd_req_o <= 1'b0;
      ok_result_o <= 1'b0;
      force_active_o <= 1'b0;
      idle_block_o <= 1'b0;
      uart_enable_o <= 1'b0;
      rx_ready_o <= 1'b0;
    end else begin
      pin_oe_o <= init_reg; // R8
      rxd_o <= init_reg ? tx_line : 1'b1; // R9
      if (!init_reg)
        cts_n_o <= 1'b1;
      else if (mux_en)
        cts_n_o <= !uart_en_now; // R13
      else if (hwfc_en)
        cts_n_o <= !can_accept; // R11 R12
      else
        cts_n_o <= 1'b0; // R11
      dsr_n_o <= dsr_mode ? (op_mode_i != `UML_MODE_DATA) : !init_reg; // R4
      dcd_n_o <= dcd_mode ? !carrier_i : !init_reg; // R6 R22
      online_cmd_req_o <= dtr_mode && dtr_fall_off && op_mode_i == `UML_MODE_DATA; // R5
      ok_result_o <= dtr_mode && dtr_fall_off && op_mode_i == `UML_MODE_DATA; // R5
      force_active_o <= psv_rts && (rts_on || !wake_done); // R18
      idle_block_o <= psv_rts && rts_on; // R19
      uart_enable_o <= init_reg && uart_en_now; // R19
      rx_ready_o <= rx_valid_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // ahb-lite data phase; zero wait, always okay
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h0000_0000;
      if (ahb_go && !hwrite_i) begin
        case (haddr_i[7:0])
          `UML_OFF_CTRL: hrdata_o <= ctrl_reg;
          `UML_OFF_STAT: hrdata_o <= {24'h000000, mux_fc_on && mux_en, rx_drop_reg,
            rx_valid_reg, tx_busy || tx_pend_reg, !rts_lvl, !dtr_n_i, uart_en_now,
            autobaud_en && (`UML_AUTOBAUD_MAX >= 460800)}; // R21
          `UML_OFF_RXD: hrdata_o <= {24'h000000, rx_data_reg};
          `UML_OFF_BAUD: hrdata_o <= {16'h0000, baud_div_reg};
          default: hrdata_o <= {29'h00000000, mux_ch};
        endcase
      end
    end
  end
endmodule // uml_line_ctrl

// ===== uml_consts.vh
// Purpose: constants for the modem-side uart line control block
// Assumes: 250 MHz system clock, ahb-lite register access, 32-bit words
// Notes: Function
// Function
// [R1] default frame eight data, no parity, one stop
// [R2] single-shot autobaud enabled after boot
// [R3] hardware rts/cts flow control default on
// [R4] dsr on in data mode, off otherwise
// [R5] dtr on-to-off enters online command, emits ok
// [R6] dcd follows carrier detect status
// [R7] mux off by default; channels 0 ctrl, 1-5, 6
// [R8] pins tri-stated, reset state, then init active
// [R9] serial data output idles high until data
// [R10] serial data input pulled up high
// [R11] cts driven on at uart init
// [R12] cts on when uart can accept data
// [R13] under mux, cts shows only power state
// [R14] first char in idle invalid without flow control
// [R15] rts input pulled up high by default
// [R16] rts off pauses transmission until on
// [R17] stop transmitting within two characters of rts off
// [R18] ps mode 2: rts rising wakes, ~20 ms settle
// [R19] ps mode 2: rts on blocks idle, off disables
// [R20] selectable frame formats 8n1 8e1 8o1 8n2 7e1 7o1
// [R21] autobaud not above 460800 b/s
// [R22] mode, carrier, power state come from processor
`ifndef UML_CONSTS_VH
`define UML_CONSTS_VH
`define UML_OFF_CTRL 8'h00
`define UML_OFF_STAT 8'h04
`define UML_OFF_TXD 8'h08
`define UML_OFF_RXD 8'h0c
`define UML_OFF_BAUD 8'h10
`define UML_CTRL_RST 32'h0000_000f
`define UML_FMT_8N1 3'h0
`define UML_FMT_8E1 3'h1
`define UML_FMT_8O1 3'h2
`define UML_FMT_8N2 3'h3
`define UML_FMT_7E1 3'h4
`define UML_FMT_7O1 3'h5
`define UML_MODE_CMD 2'h0
`define UML_MODE_ONL 2'h1
`define UML_MODE_DATA 2'h2
`define UML_PSV_OFF 2'h0
`define UML_PSV_RTS 2'h2
`define UML_MUX_CH_MAX 3'h6
`define UML_AUTOBAUD_MAX 460800
`define UML_WAKE_MS 20
`define UML_CLK_MHZ 250
`define UML_WAKE_CYC (`UML_WAKE_MS * 1000 * `UML_CLK_MHZ)
`define UML_BAUD_DIV_RST 16'h0870
`endif

// ===== uml_tx_shift.v
// Purpose: transmit serializer for one character with pause support
// Assumes: bit period is baud_div_i plus one clock cycles
// Notes: pause is honoured only between characters
`timescale 1ns/1ns
`include "uml_consts.vh"
module uml_tx_shift (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [15:0] baud_div_i,
  input wire [2:0] fmt_i,
  input wire start_i,
  input wire [7:0] data_i,
  output reg busy_o,
  output reg txd_o
);
  reg [15:0] div_reg;
  reg [3:0] bit_reg;
  reg [3:0] nbits_reg;
  reg [11:0] sh_reg;
  wire par = fmt_i[2] ? ^data_i[6:0] : ^data_i;
  wire odd = (fmt_i == `UML_FMT_8O1) || (fmt_i == `UML_FMT_7O1);
  ////////////////////////////////////////////////////////////////////
  // frame builder: lsb first, start bit low, stop bits high
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      txd_o <= 1'b1; // R9
      div_reg <= 16'h0000;
      bit_reg <= 4'h0;
      nbits_reg <= 4'h0;
      sh_reg <= 12'hfff;
    end else if (!busy_o) begin
      txd_o <= 1'b1; // R9
      if (start_i) begin
        busy_o <= 1'b1;
        div_reg <= baud_div_i;
        bit_reg <= 4'h0;
        txd_o <= 1'b0;
        case (fmt_i) // R20
          `UML_FMT_8N1: begin
            sh_reg <= {4'hf, data_i};
            nbits_reg <= 4'h9;
          end
          `UML_FMT_8N2: begin
            sh_reg <= {4'hf, data_i};
            nbits_reg <= 4'ha;
          end
          `UML_FMT_7E1, `UML_FMT_7O1: begin
            sh_reg <= {4'hf, par ^ odd, data_i[6:0]};
            nbits_reg <= 4'h9;
          end
          default: begin
            sh_reg <= {3'h7, par ^ odd, data_i};
            nbits_reg <= 4'ha;
          end
        endcase
      end
    end else if (div_reg == 16'h0000) begin
      div_reg <= baud_div_i;
      if (bit_reg == nbits_reg) begin
        busy_o <= 1'b0;
        txd_o <= 1'b1;
      end else begin
        txd_o <= sh_reg[0];
        sh_reg <= {1'b1, sh_reg[11:1]};
        bit_reg <= bit_reg + 4'h1;
      end
    end else begin
      div_reg <= div_reg - 16'h0001;
    end
  end
endmodule // uml_tx_shift

// ===== uml_line_ctrl_props.sv
// Purpose: concurrent checks on the line control pins and pulses
// Assumes: ctrl writes seen on the bus are shadowed here
// Notes: the design's ctrl copy is not a port, hence the local shadow
`timescale 1ns/1ns
`include "uml_consts.vh"
module uml_line_ctrl_props #(
  parameter WAKE_CYC = 50
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire [1:0] op_mode_i,
  input wire carrier_i,
  input wire [1:0] psv_mode_i,
  input wire rts_n_i,
  input wire rts_driven_i,
  input wire rxd_o,
  input wire pin_oe_o,
  input wire cts_n_o,
  input wire dsr_n_o,
  input wire dcd_n_o,
  input wire online_cmd_req_o,
  input wire ok_result_o,
  input wire idle_block_o,
  input wire uart_enable_o
);
  reg wr_reg;
  reg [5:0] sh_reg;
  wire rts_on = rts_driven_i && !rts_n_i;
  wire psv_rts = pin_oe_o && psv_mode_i == `UML_PSV_RTS && !sh_reg[1];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // shadow ctrl: address phase flag, then data phase capture
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= 1'b0;
      sh_reg <= 6'h0f;
    end else if (hready_i) begin
      wr_reg <= hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == `UML_OFF_CTRL;
      if (wr_reg) sh_reg <= hwdata_i[5:0];
    end
  end
  // three-cycle windows leave room for the output register latency
  a_pins_pre_init: assert property (!pin_oe_o |-> rxd_o && cts_n_o && dsr_n_o && dcd_n_o)
    else $error("line driven before init");
  a_dsr_data_on: assert property ((pin_oe_o && sh_reg[2] && op_mode_i == `UML_MODE_DATA)[*3]
    |-> !dsr_n_o) else $error("dsr not on in data mode");
  a_dsr_cmd_off: assert property ((pin_oe_o && sh_reg[2] && op_mode_i != `UML_MODE_DATA)[*3]
    |-> dsr_n_o) else $error("dsr on outside data mode");
  a_dcd_follows: assert property ((pin_oe_o && sh_reg[3] && $stable(carrier_i))[*3]
    |-> dcd_n_o == !carrier_i) else $error("dcd not following carrier");
  a_online_one_cycle: assert property (online_cmd_req_o |=> !online_cmd_req_o)
    else $error("online request longer than one cycle");
  a_ok_one_cycle: assert property (ok_result_o |=> !ok_result_o)
    else $error("ok result longer than one cycle");
  a_psv_rts_hold: assert property ((psv_rts && rts_on)[*3] |-> idle_block_o)
    else $error("idle not blocked while rts on");
  a_psv_rts_off: assert property ((psv_rts && !rts_on)[*3] |-> !uart_enable_o && !idle_block_o)
    else $error("uart kept up while rts off");
endmodule // uml_line_ctrl_props
bind uml_line_ctrl uml_line_ctrl_props #(.WAKE_CYC(WAKE_CYC)) u_props (.sys_clk_i, .rst_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .op_mode_i, .carrier_i,
  .psv_mode_i, .rts_n_i, .rts_driven_i, .rxd_o, .pin_oe_o, .cts_n_o, .dsr_n_o, .dcd_n_o,
  .online_cmd_req_o, .ok_result_o, .idle_block_o, .uart_enable_o);

// ===== uml_host_model.sv
// Purpose: host terminal model on the uart pins
// Assumes: 8n1 frames of BIT clock cycles per bit
// Notes: a released pin shows low, the worst case for the pull-up
`timescale 1ns/1ns
module uml_host_model #(
  parameter BIT = 4
) (
  input wire sys_clk_i,
  input wire rxd_i,
  output reg txd_n_o,
  output reg txd_drv_o,
  output reg rts_n_o,
  output reg rts_drv_o,
  output reg dtr_n_o
);
  integer rx_cnt = 0;
  integer i;
  reg [7:0] rx_last = 8'h00;
  initial begin
    txd_n_o = 1'b0;
    txd_drv_o = 1'b0;
    rts_n_o = 1'b0;
    rts_drv_o = 1'b0;
    dtr_n_o = 1'b1;
  end
  ////////////////////////////////////////
  // pin drivers, changed just after a clock edge
  task set_rts(input d, input n);
    @(posedge sys_clk_i);
    rts_drv_o <= d;
    rts_n_o <= d & n;
  endtask
  task set_dtr(input n);
    @(posedge sys_clk_i);
    dtr_n_o <= n;
  endtask
  // frame sent lsb first; the line stays driven high after the stop bit
  task send(input [7:0] b);
    reg [9:0] f;
    integer k;
    f = {1'b1, b, 1'b0};
    for (k = 0; k < 10; k = k + 1) begin
      @(posedge sys_clk_i);
      txd_drv_o <= 1'b1;
      txd_n_o <= f[k];
      repeat (BIT - 1) @(posedge sys_clk_i);
    end
  endtask
  // always ready to take characters, even with rts off
  always begin
    @(negedge rxd_i);
    repeat (BIT / 2) @(posedge sys_clk_i);
    for (i = 0; i < 8; i = i + 1) begin
      repeat (BIT) @(posedge sys_clk_i);
      rx_last[i] = rxd_i;
    end
    repeat (BIT) @(posedge sys_clk_i);
    rx_cnt = rx_cnt + 1;
  end
endmodule // uml_host_model

// ===== uml_line_ctrl_tb.sv
// Purpose: directed bench for the modem-side line control block
// Assumes: ahb-lite master, bit time cut to 4 cycles
// Notes: wake timer cut to 50 cycles to keep the run short
`timescale 1ns/1ns
`include "uml_consts.vh"
module uml_line_ctrl_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg boot = 1'b0;
  reg [1:0] mode = 2'h0;
  reg car = 1'b0;
  reg [1:0] psv = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg lpi = 1'b0;
  reg [31:0] q;
  wire [31:0] hrdata;
  wire hrdy, hresp, rxd, oe, cts_n, dsr_n, dcd_n, onl, ok, fact, iblk, uen, rxr;
  wire txd_n, txd_drv, rts_n, rts_drv, dtr_n;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer n_onl = 0;
  integer n_ok = 0;
  always #2 clk = ~clk;
  // pulse counters for the dtr action
  always @(posedge clk) begin
    if (onl === 1'b1) n_onl <= n_onl + 1;
    if (ok === 1'b1) n_ok <= n_ok + 1;
  end
  uml_line_ctrl #(.WAKE_CYC(50)) u_dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .boot_done_i(boot), .op_mode_i(mode), .carrier_i(car), .psv_mode_i(psv),
    .low_power_idle_i(lpi), .txd_n_i(txd_n), .txd_driven_i(txd_drv), .rts_n_i(rts_n),
    .rts_driven_i(rts_drv), .dtr_n_i(dtr_n), .rxd_o(rxd), .pin_oe_o(oe), .cts_n_o(cts_n),
    .dsr_n_o(dsr_n), .dcd_n_o(dcd_n), .online_cmd_req_o(onl), .ok_result_o(ok),
    .force_active_o(fact), .idle_block_o(iblk), .uart_enable_o(uen), .rx_ready_o(rxr));
  uml_host_model #(.BIT(4)) u_host (.sys_clk_i(clk), .rxd_i(rxd), .txd_n_o(txd_n),
    .txd_drv_o(txd_drv), .rts_n_o(rts_n), .rts_drv_o(rts_drv), .dtr_n_o(dtr_n));
  ////////////////////////////////////////
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input [8*5:1] nm, input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0s exp %h got %h", nm, exp, got);
    end
  endtask
  // bounded wait: ready high on the bus, or n characters at the host
  task hold(input integer n);
    integer k;
    k = 0;
    @(posedge clk);
    while ((n < 0 ? hrdy !== 1'b1 : u_host.rx_cnt < n) && k < 400) begin
      @(posedge clk);
      k = k + 1;
    end
    if (k >= 400) begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  endtask
  // one single ahb-lite transfer; read data lands in q
  task ahb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hold(-1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold(-1);
    q = hrdata;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pins", {rxd, cts_n, dsr_n, dcd_n, oe}, 5'h1e);
    boot <= 1'b1;
    repeat (4) @(posedge clk);
    chk("init", {rxd, cts_n, dsr_n, dcd_n, oe}, 5'h17);
    ahb(0, `UML_OFF_CTRL, 0);
    chk("ctrl", q, `UML_CTRL_RST);
    chk("resp", hresp, 0);
    ahb(0, `UML_OFF_BAUD, 0);
    chk("baud", q, 32'h870);
    ahb(0, 8'h20, 0);
    chk("unmap", q, 32'h0);
    ahb(0, `UML_OFF_STAT, 0);
    chk("rxv", q & 32'h20, 32'h0);
    mode <= `UML_MODE_DATA;
    car <= 1'b1;
    repeat (4) @(posedge clk);
    chk("dsdc", {dsr_n, dcd_n}, 2'h0);
    ahb(1, `UML_OFF_CTRL, 32'h1f);
    u_host.set_dtr(1'b0);
    repeat (4) @(posedge clk);
    u_host.set_dtr(1'b1);
    repeat (6) @(posedge clk);
    chk("dtr", {n_onl[3:0], n_ok[3:0]}, 8'h11);
    ahb(1, `UML_OFF_BAUD, 32'h3);
    u_host.set_rts(1'b1, 1'b0);
    ahb(1, `UML_OFF_TXD, 32'ha5);
    hold(1);
    chk("tx1", u_host.rx_last, 8'ha5);
    u_host.set_rts(1'b1, 1'b1);
    ahb(1, `UML_OFF_TXD, 32'h5a);
    repeat (200) @(posedge clk);
    chk("pause", u_host.rx_cnt, 1);
    u_host.set_rts(1'b1, 1'b0);
    hold(2);
    chk("tx2", u_host.rx_last, 8'h5a);
    u_host.send(8'h3c);
    repeat (8) @(posedge clk);
    ahb(0, `UML_OFF_STAT, 0);
    chk("rxv", q & 32'h20, 32'h20);
    chk("ctsof", cts_n, 1);
    chk("rxr", rxr, 1);
    ahb(0, `UML_OFF_RXD, 0);
    chk("rxd", q & 32'hff, 32'h3c);
    repeat (3) @(posedge clk);
    chk("ctson", cts_n, 0);
    ahb(1, `UML_OFF_CTRL, 32'h1d);
    u_host.set_rts(1'b0, 1'b0);
    psv <= `UML_PSV_RTS;
    repeat (8) @(posedge clk);
    chk("psvof", {uen, iblk, fact}, 3'h0);
    u_host.set_rts(1'b1, 1'b0);
    repeat (60) @(posedge clk);
    chk("psvon", {uen, iblk, fact}, 3'h7);
    give_verdict;
  end
endmodule // uml_line_ctrl_tb
